/* psrb_defs.svh */
// Purpose: constants for the page-zero status register bank
// Assumes: byte-wide register port, 16-bit register address (page:offset)
// Notes:   offsets are the in-page low byte
`ifndef PSRB_DEFS_SVH
`define PSRB_DEFS_SVH

`define PSRB_OFS_DIE_ID       8'h00
`define PSRB_OFS_PAGE         8'h01
`define PSRB_OFS_PART_LO      8'h02
`define PSRB_OFS_PART_HI      8'h03
`define PSRB_OFS_GRADE        8'h04
`define PSRB_OFS_DEV_REV      8'h05
`define PSRB_OFS_TEMP_CODE    8'h09
`define PSRB_OFS_PKG          8'h0a
`define PSRB_OFS_BUS_ADDR     8'h0b
`define PSRB_OFS_LIVE         8'h0c
`define PSRB_OFS_INLOSS       8'h0d
`define PSRB_OFS_STICKY       8'h11
`define PSRB_OFS_INLOSS_STK   8'h12
`define PSRB_OFS_MASK         8'h17
`define PSRB_OFS_INLOSS_MASK  8'h18
`define PSRB_OFS_SOFT_RESET   8'h1c

`define PSRB_STATUS_BITS      8'h2f
`define PSRB_INLOSS_BITS      8'h0f
`define PSRB_SOFT_RESET_BIT   0

`define PSRB_RST_PAGE         8'h00
`define PSRB_RST_BUS_ADDR     7'h74
`define PSRB_RST_MASK         8'h00

`define PSRB_SOFT_RESET_NS    16
`define PSRB_CLK_NS           4
`define PSRB_SOFT_RESET_CYC   ((`PSRB_SOFT_RESET_NS + `PSRB_CLK_NS - 1) / `PSRB_CLK_NS)

`endif

/* psrb_pkg.sv */
// Purpose: types for the page-zero status register bank
// Assumes: nothing beyond the defs header
// Notes:   soft-reset sequencer states, gray coded
`default_nettype none
package psrb_pkg;
    typedef enum logic [1:0] {
        PSRB_IDLE  = 2'b00,
        PSRB_PULSE = 2'b01,
        PSRB_ALIGN = 2'b11
    } psrb_srst_e;
endpackage
`default_nettype wire

/* psrb_bank.sv */
// Purpose: page-zero control and status registers of a clock generator
// Assumes: byte register port from the serial bus engine, inputs synchronous to mclk
// Notes:   identity values are parameters; defaults are arbitrary
// Notes on behaviour
// - page select register at offset 0x01 of every page, read and write
// - page select eight bits; it forms the upper address byte
// - four-bit die revision readable at 0x0000, writes ignored
// - sixteen-bit base part id at 0x0002 low, 0x0003 high, decimal nibbles
// - eight-bit speed grade at 0x0004, codes zero to three mean A to D
// - eight-bit device revision at 0x0005, zero means revision A
// - writable seven-bit bus target address at 0x000B bits 6:0
// - live bit 0 at 0x000C reads one while calibrating
// - live bit 1 reads one when crystal pin a has no signal
// - live bit 2 reads one when phase detector lacks any reference
// - live bit 3 reads one while the loop is unlocked
// - live bit 5 reads one on serial bus timeout
// - per-input loss live at 0x000D bits 3:0, feedback down to input 0
// - live status latched into sticky bits at 0x0011, host writes zero to clear
// - input loss latched into sticky bits 3:0 at 0x0012, zero clears each
// - mask bits at 0x0017 block matching sticky flags from interrupt
// - mask bits 3:0 at 0x0018 block input loss flags from interrupt
// - writing one to 0x001C bit 0 resets logic but keeps registers
// - soft reset bit clears itself, host never writes it back
// - soft reset realigns all output clocks
`timescale 1ns/1ps
`default_nettype none
`include "psrb_defs.svh"

module psrb_bank
    import psrb_pkg::*;
#(
    parameter logic [3:0]  DIE_REVISION = 4'h0,
    parameter logic [15:0] PART_ID      = 16'h1234,
    parameter logic [7:0]  GRADE_CODE   = 8'h00,
    parameter logic [7:0]  DEV_REV      = 8'h00,
    parameter logic [7:0]  TEMP_CODE    = 8'h00,
    parameter logic [7:0]  PKG_CODE     = 8'h00
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // register port from the serial bus engine
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output var  logic [7:0]  reg_rdata,
    output var  logic [7:0]  cur_page,
    // live conditions
    input  wire logic        calibrating_status,
    input  wire logic        crystal_input_loss,
    input  wire logic        reference_loss,
    input  wire logic        pll_unlocked,
    input  wire logic        bus_timeout_status,
    input  wire logic [3:0]  input_loss_live,
    // outputs to the rest of the device
    output var  logic [6:0]  bus_target_address,
    output var  logic        irq,
    output var  logic        soft_reset_pulse,
    output var  logic        output_align
);

    logic [7:0] page_select;
    logic [7:0] live_status;
    logic [7:0] input_loss_q;
    logic [7:0] sticky_status_flags;
    logic [7:0] input_loss_sticky;
    logic [7:0] status_interrupt_mask;
    logic [7:0] input_loss_interrupt_mask;
    logic [7:0] next_rdata;
    logic       page0;
    logic       wr_p0;
    psrb_srst_e srst_state;
    logic [3:0] srst_cnt;

    localparam logic [3:0] SRST_CYC = 4'(`PSRB_SOFT_RESET_CYC);

    assign page0 = (page_select == 8'h00);
    assign wr_p0 = reg_wr && page0;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            page_select <= `PSRB_RST_PAGE;
        end else if (reg_wr && reg_addr == `PSRB_OFS_PAGE) begin
            page_select <= reg_wdata;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cur_page <= 8'h00;
        end else begin
            cur_page <= (reg_wr && reg_addr == `PSRB_OFS_PAGE) ? reg_wdata : page_select;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bus_target_address <= `PSRB_RST_BUS_ADDR;
        end else if (wr_p0 && reg_addr == `PSRB_OFS_BUS_ADDR) begin
            bus_target_address <= reg_wdata[6:0];
        end
    end

    // input loss follows live, no latch
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            live_status  <= 8'h00;
            input_loss_q <= 8'h00;
        end else begin
            live_status  <= {2'h0, bus_timeout_status, 1'b0, pll_unlocked,
                             reference_loss, crystal_input_loss, calibrating_status};
            input_loss_q <= {4'h0, input_loss_live};
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sticky_status_flags <= 8'h00;
        end else if (wr_p0 && reg_addr == `PSRB_OFS_STICKY) begin
            sticky_status_flags <= (sticky_status_flags & reg_wdata | live_status)
                                   & `PSRB_STATUS_BITS;
        end else begin
            sticky_status_flags <= (sticky_status_flags | live_status) & `PSRB_STATUS_BITS;
        end
    end

    // sticky input loss, per bit clear
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            input_loss_sticky <= 8'h00;
        end else if (wr_p0 && reg_addr == `PSRB_OFS_INLOSS_STK) begin
            input_loss_sticky <= (input_loss_sticky & reg_wdata | input_loss_q)
                                 & `PSRB_INLOSS_BITS;
        end else begin
            input_loss_sticky <= (input_loss_sticky | input_loss_q) & `PSRB_INLOSS_BITS;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            status_interrupt_mask     <= `PSRB_RST_MASK;
            input_loss_interrupt_mask <= `PSRB_RST_MASK;
        end else if (wr_p0) begin
            if (reg_addr == `PSRB_OFS_MASK) begin
                status_interrupt_mask <= reg_wdata & `PSRB_STATUS_BITS;
            end
            if (reg_addr == `PSRB_OFS_INLOSS_MASK) begin
                input_loss_interrupt_mask <= reg_wdata & `PSRB_INLOSS_BITS;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(sticky_status_flags & ~status_interrupt_mask)
                 | |(input_loss_sticky & ~input_loss_interrupt_mask);
        end
    end

    // soft reset, self clearing
    // registers above are untouched; only downstream logic sees the pulse
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            srst_state       <= PSRB_IDLE;
            srst_cnt         <= 4'h0;
            soft_reset_pulse <= 1'b0;
            output_align     <= 1'b0;
        end else begin
            unique case (srst_state)
                PSRB_IDLE: begin
                    output_align <= 1'b0;
                    if (wr_p0 && reg_addr == `PSRB_OFS_SOFT_RESET
                        && reg_wdata[`PSRB_SOFT_RESET_BIT]) begin
                        srst_state       <= PSRB_PULSE;
                        srst_cnt         <= SRST_CYC - 4'h1;
                        soft_reset_pulse <= 1'b1;
                    end
                end
                PSRB_PULSE: begin
                    if (srst_cnt == 4'h0) begin
                        soft_reset_pulse <= 1'b0;
                        srst_state       <= PSRB_ALIGN;
                        output_align     <= 1'b1;
                    end else begin
                        srst_cnt <= srst_cnt - 4'h1;
                    end
                end
                PSRB_ALIGN: begin
                    output_align <= 1'b0;
                    srst_state   <= PSRB_IDLE;
                end
                // unused code 2'b10 falls back to idle
                default: srst_state <= PSRB_IDLE;
            endcase
        end
    end

    always_comb begin
        next_rdata = 8'h00;
        if (reg_addr == `PSRB_OFS_PAGE) begin
            next_rdata = page_select;
        end else if (page0) begin
            unique case (reg_addr)
                `PSRB_OFS_DIE_ID:      next_rdata = {4'h0, DIE_REVISION};
                `PSRB_OFS_PART_LO:     next_rdata = PART_ID[7:0];
                `PSRB_OFS_PART_HI:     next_rdata = PART_ID[15:8];
                `PSRB_OFS_GRADE:       next_rdata = GRADE_CODE;
                `PSRB_OFS_DEV_REV:     next_rdata = DEV_REV;
                `PSRB_OFS_TEMP_CODE:   next_rdata = TEMP_CODE;
                `PSRB_OFS_PKG:         next_rdata = PKG_CODE;
                `PSRB_OFS_BUS_ADDR:    next_rdata = {1'b0, bus_target_address};
                `PSRB_OFS_LIVE:        next_rdata = live_status;
                `PSRB_OFS_INLOSS:      next_rdata = input_loss_q;
                `PSRB_OFS_STICKY:      next_rdata = sticky_status_flags;
                `PSRB_OFS_INLOSS_STK:  next_rdata = input_loss_sticky;
                `PSRB_OFS_MASK:        next_rdata = status_interrupt_mask;
                `PSRB_OFS_INLOSS_MASK: next_rdata = input_loss_interrupt_mask;
                default:               next_rdata = 8'h00;
            endcase
        end
    end

    // read data registered; soft reset register reads zero
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    page_write_a: assert property (@(posedge mclk) disable iff (rst)
        reg_wr && reg_addr == `PSRB_OFS_PAGE |=> page_select == $past(reg_wdata))
        else $error("page select did not take written value");

    page_read_a: assert property (@(posedge mclk) disable iff (rst)
        reg_rd && reg_addr == `PSRB_OFS_PAGE |=> reg_rdata == $past(page_select))
        else $error("page select read back wrong");

    page_out_a: assert property (@(posedge mclk) disable iff (rst)
        !reg_wr |=> cur_page == $past(page_select))
        else $error("upper address byte differs from page");

    off_page_a: assert property (@(posedge mclk) disable iff (rst)
        reg_rd && !page0 && reg_addr != `PSRB_OFS_PAGE |=> reg_rdata == 8'h00)
        else $error("register outside page zero read nonzero");

    die_ident_a: assert property (@(posedge mclk) disable iff (rst)
        reg_rd && page0 && reg_addr == `PSRB_OFS_DIE_ID |=> reg_rdata == {4'h0, DIE_REVISION})
        else $error("die revision read wrong");

    part_id_a: assert property (@(posedge mclk) disable iff (rst)
        reg_rd && page0 && reg_addr == `PSRB_OFS_PART_HI |=> reg_rdata == PART_ID[15:8])
        else $error("part id high byte wrong");

    part_lo_a: assert property (@(posedge mclk) disable iff (rst)
        reg_rd && page0 && reg_addr == `PSRB_OFS_PART_LO |=> reg_rdata == PART_ID[7:0])
        else $error("part id low byte wrong");

    grade_read_a: assert property (@(posedge mclk) disable iff (rst)
        reg_rd && page0 && reg_addr == `PSRB_OFS_GRADE |=> reg_rdata == GRADE_CODE)
        else $error("speed grade read wrong");

    dev_code_a: assert property (@(posedge mclk) disable iff (rst)
        reg_rd && page0 && reg_addr == `PSRB_OFS_DEV_REV |=> reg_rdata == DEV_REV)
        else $error("device revision read wrong");

    bus_addr_a: assert property (@(posedge mclk) disable iff (rst)
        wr_p0 && reg_addr == `PSRB_OFS_BUS_ADDR |=> bus_target_address == $past(reg_wdata[6:0]))
        else $error("bus target address did not take write");

    live_bits_a: assert property (@(posedge mclk) disable iff (rst)
        1'b1 |=> live_status == {2'h0, $past(bus_timeout_status), 1'b0, $past(pll_unlocked),
                                 $past(reference_loss), $past(crystal_input_loss),
                                 $past(calibrating_status)})
        else $error("live status bits misplaced");

    loss_live_a: assert property (@(posedge mclk) disable iff (rst)
        1'b1 |=> input_loss_q[3:0] == $past(input_loss_live))
        else $error("input loss live does not follow input");

    sticky_set_a: assert property (@(posedge mclk) disable iff (rst)
        live_status[3] |=> sticky_status_flags[3])
        else $error("sticky status lost an event");

    sticky_hold_a: assert property (@(posedge mclk) disable iff (rst)
        sticky_status_flags[3] && !(wr_p0 && reg_addr == `PSRB_OFS_STICKY && !reg_wdata[3])
        |=> sticky_status_flags[3])
        else $error("sticky status dropped without a clear");

    loss_set_a: assert property (@(posedge mclk) disable iff (rst)
        input_loss_q[1] |=> input_loss_sticky[1])
        else $error("input loss flag did not latch");

    loss_clear_a: assert property (@(posedge mclk) disable iff (rst)
        wr_p0 && reg_addr == `PSRB_OFS_INLOSS_STK && !reg_wdata[0] && !input_loss_q[0]
        |=> !input_loss_sticky[0])
        else $error("input loss flag not cleared by zero write");

    irq_raise_a: assert property (@(posedge mclk) disable iff (rst)
        (input_loss_sticky[2] && !input_loss_interrupt_mask[2]) |=> irq)
        else $error("unmasked flag did not raise interrupt");

    status_irq_a: assert property (@(posedge mclk) disable iff (rst)
        sticky_status_flags[5] && !status_interrupt_mask[5] |=> irq)
        else $error("unmasked status flag did not raise interrupt");

    irq_mask_a: assert property (@(posedge mclk) disable iff (rst)
        (sticky_status_flags & ~status_interrupt_mask) == 8'h00
        && (input_loss_sticky & ~input_loss_interrupt_mask) == 8'h00 |=> !irq)
        else $error("interrupt raised with all flags masked");

    soft_pulse_a: assert property (@(posedge mclk) disable iff (rst)
        srst_state == PSRB_IDLE && wr_p0 && reg_addr == `PSRB_OFS_SOFT_RESET && reg_wdata[0]
        |=> soft_reset_pulse [*4] ##1 !soft_reset_pulse && output_align)
        else $error("soft reset pulse length or align wrong");

    soft_zero_a: assert property (@(posedge mclk) disable iff (rst)
        srst_state == PSRB_IDLE && wr_p0 && reg_addr == `PSRB_OFS_SOFT_RESET
        && !reg_wdata[0] |=> !soft_reset_pulse)
        else $error("soft reset fired on a zero write");

endmodule
`default_nettype wire

/* psrb_host.sv */
// Purpose: host model driving the register port of the bank
// Assumes: one access at a time, strobes one cycle wide
// Notes:   idle write data is inverted so a stale byte never looks valid
`timescale 1ns/1ps
`default_nettype none
module psrb_host (
    // clock
    input  wire logic       mclk,
    // register port
    output var  logic [7:0] reg_addr,
    output var  logic       reg_wr,
    output var  logic       reg_rd,
    output var  logic [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

/* tb_top.sv */
// Purpose: self-checking bench for the page-zero register bank
// Assumes: host model owns the register port
// Notes:   identity parameter values are arbitrary
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [3:0]  DIE  = 4'h3;
    localparam logic [15:0] PART = 16'h9876;
    localparam logic [7:0]  GRD  = 8'h02;
    logic       mclk, rst, cal, xtl, rfl, unl, tmo, irq, srp, aln;
    logic [3:0] inl;
    logic [7:0] addr, wdat, rdat, page, stk, istk, msk, imsk;
    logic       wr, rd;
    logic [6:0] bta;
    int         num_errors, n_compared, seed, cycles, np, na, lp, ia;
    logic [31:0] v, w;

    psrb_host i_psrb_host (.mclk(mclk), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
        .reg_wdata(wdat), .reg_rdata(rdat));
    psrb_bank #(.DIE_REVISION(DIE), .PART_ID(PART), .GRADE_CODE(GRD)) i_psrb_bank (
        .mclk(mclk), .rst(rst), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
        .reg_wdata(wdat), .reg_rdata(rdat), .cur_page(page), .calibrating_status(cal),
        .crystal_input_loss(xtl), .reference_loss(rfl), .pll_unlocked(unl),
        .bus_timeout_status(tmo), .input_loss_live(inl), .bus_target_address(bta),
        .irq(irq), .soft_reset_pulse(srp), .output_align(aln));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task automatic close_out;
        if (num_errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            num_errors++;
            close_out();
        end
    end
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [7:0] d;
        i_psrb_host.rd(a, d);
        cmp_byte(d, exp, what);
    endtask
    task automatic set_live(input logic [7:0] s, input logic [3:0] l);
        @(posedge mclk);
        {tmo, unl, rfl, xtl, cal} <= {s[5], s[3:0]};
        inl <= l;
        stk = stk | (s & 8'h2f);
        istk = istk | {4'h0, l};
    endtask
    // one watch window counts pulse and align cycles
    task automatic watch;
        np = 0; na = 0; lp = -1; ia = -2;
        // first look just after the write edge, where the pulse is already up
        for (int i = 0; i < 10; i++) begin
            #1;
            if (srp === 1'b1) begin np++; lp = i; end
            if (aln === 1'b1) begin na++; ia = i; end
            @(posedge mclk);
        end
    endtask

    initial begin
        seed = 7078; num_errors = 0; n_compared = 0; cycles = 0;
        stk = 8'h00; istk = 8'h00; msk = 8'h00; imsk = 8'h00;
        rst = 1'b1; {tmo, unl, rfl, xtl, cal} = 5'h00; inl = 4'h0;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rdchk(8'h01, 8'h00, "page rst");
        rdchk(8'h0b, 8'h74, "addr rst");
        i_psrb_host.wr(8'h00, 8'hff);
        rdchk(8'h00, {4'h0, DIE}, "die rev");
        rdchk(8'h02, PART[7:0], "part lo");
        rdchk(8'h03, PART[15:8], "part hi");
        rdchk(8'h04, GRD, "grade");
        rdchk(8'h05, 8'h00, "dev rev");
        rdchk(8'h09, 8'h00, "temp code");
        rdchk(8'h0a, 8'h00, "pkg code");
        rdchk(8'h06, 8'h00, "unmapped");
        i_psrb_host.wr(8'h0b, 8'hff);
        rdchk(8'h0b, 8'h7f, "bus addr");
        cmp_byte({1'b0, bta}, 8'h7f, "addr port");
        i_psrb_host.wr(8'h01, 8'h05);
        rdchk(8'h01, 8'h05, "page rd");
        cmp_byte(page, 8'h05, "cur page");
        i_psrb_host.wr(8'h0b, 8'h11);
        rdchk(8'h0b, 8'h00, "other page");
        i_psrb_host.wr(8'h01, 8'h00);
        rdchk(8'h0b, 8'h7f, "page back");
        for (int i = 0; i < 8; i++) begin
            v = $random(seed);
            w = $random(seed);
            i_psrb_host.wr(8'h17, w[7:0]);
            msk = w[7:0] & 8'h2f;
            i_psrb_host.wr(8'h18, w[15:8]);
            imsk = w[15:8] & 8'h0f;
            set_live(v[7:0], v[11:8]);
            repeat (4) @(posedge mclk);
            #1;
            cmp_byte({7'h0, irq}, {7'h0, |(stk & ~msk) | |(istk & ~imsk)}, "irq");
            rdchk(8'h0c, v[7:0] & 8'h2f, "live");
            rdchk(8'h0d, {4'h0, v[11:8]}, "in loss");
            rdchk(8'h11, stk, "sticky");
            rdchk(8'h12, istk, "in sticky");
            rdchk(8'h18, imsk, "in mask");
            rdchk(8'h17, msk, "mask");
            // set wins over a clear while the condition is live
            i_psrb_host.wr(8'h11, w[23:16]);
            stk = (stk & w[23:16]) | (v[7:0] & 8'h2f);
            i_psrb_host.wr(8'h12, w[31:24]);
            istk = (istk & w[31:24] & 8'h0f) | {4'h0, v[11:8]};
        end
        set_live(8'h00, 4'h0);
        i_psrb_host.wr(8'h17, 8'h00);
        i_psrb_host.wr(8'h11, 8'h00);
        i_psrb_host.wr(8'h12, 8'h00);
        rdchk(8'h11, 8'h00, "cleared");
        rdchk(8'h12, 8'h00, "in cleared");
        cmp_byte({7'h0, irq}, 8'h00, "irq low");
        i_psrb_host.wr(8'h1c, 8'h00);
        watch();
        cmp_byte(8'(np), 8'h00, "zero write");
        i_psrb_host.wr(8'h1c, 8'h01);
        watch();
        cmp_byte(8'(np), 8'h04, "pulse len");
        cmp_byte(8'(na), 8'h01, "align");
        cmp_byte(8'(ia - lp), 8'h01, "align order");
        rdchk(8'h0b, 8'h7f, "kept");
        rdchk(8'h1c, 8'h00, "self clear");
        close_out();
    end
endmodule
`default_nettype wire
